// file: rtl/isr_status_reporting.v
`timescale 1ns/1ps
`include "isr_consts.vh"
module isr_status_reporting
(
	input wire clk_sys,
	input wire rst,
	input wire [7:0] event_set,
	input wire msg_avail,
	input wire err_avail,
	input wire cmd_clear_status,
	input wire cmd_write,
	input wire cmd_read,
	input wire [1:0] cmd_sel,
	input wire [7:0] cmd_wdata,
	input wire serial_poll,
	output reg [7:0] rd_data_ff,
	output reg rd_valid_ff,
	output reg [7:0] poll_data_ff,
	output reg poll_valid_ff,
	output wire srq_req,
	output wire [7:0] event_status,
	output wire [7:0] event_status_enable,
	output wire [7:0] status_byte,
	output wire [7:0] service_request_enable
);
	// stored state, plus the combinational next event status
	reg [7:0] event_status_ff;
	reg [7:0] event_enable_ff;
	reg [7:0] req_enable_ff;
	reg [7:0] nxt_event_status;
	// combinational helpers
	wire event_summary;
	wire master_summary;
	wire [7:0] status_byte_w;
	wire [7:0] sel_data;
	wire [7:0] status_low;
	wire [7:0] event_keep;
	wire [7:0] event_next;
	wire [7:0] enable_wdata;
	wire rd_event_hit;
	wire wr_event_enable_hit;
	wire wr_req_enable_hit;
	wire clear_events;
	wire queue_gate;
	genvar gi;
	// used-bit masks as vectors so a loop index can pick one bit
	localparam [7:0] ev_used = `ISR_EV_USED_MASK;
	localparam [7:0] sb_used = `ISR_SB_USED_MASK;

	// one decode for the register read path; writes decode through isr_hit and isr_wmask
	function [7:0] isr_pick;
		input [1:0] sel;
		input [7:0] a;
		input [7:0] b;
		input [7:0] c;
		input [7:0] d;
		begin
			case (sel)
				`ISR_SEL_EVENT_STATUS: isr_pick = a;
				`ISR_SEL_EVENT_ENABLE: isr_pick = b;
				`ISR_SEL_STATUS_BYTE: isr_pick = c;
				default: isr_pick = d;
			endcase
		end
	endfunction

	// true when the command select names the given register
	function isr_hit;
		input [1:0] sel;
		input [1:0] code;
		begin
			isr_hit = (sel == code);
		end
	endfunction

	// written mask value, unused positions of that register forced low
	function [7:0] isr_wmask;
		input [1:0] sel;
		input [7:0] data;
		begin
			case (sel)
				`ISR_SEL_EVENT_ENABLE: isr_wmask = data & `ISR_EV_USED_MASK;
				`ISR_SEL_REQ_ENABLE: isr_wmask = data & `ISR_SB_USED_MASK;
				default: isr_wmask = 8'h00;
			endcase
		end
	endfunction

	// which register a command names
	assign rd_event_hit = cmd_read & isr_hit(cmd_sel, `ISR_SEL_EVENT_STATUS);
	assign wr_event_enable_hit = cmd_write & isr_hit(cmd_sel, `ISR_SEL_EVENT_ENABLE);
	assign wr_req_enable_hit = cmd_write & isr_hit(cmd_sel, `ISR_SEL_REQ_ENABLE);

	// read or clear-status empties the event register; masks share one data path
	assign clear_events = cmd_clear_status | rd_event_hit;
	assign queue_gate = ~cmd_clear_status;
	assign enable_wdata = isr_wmask(cmd_sel, cmd_wdata);

	// summaries are combinational so the byte tracks events at once
	assign event_summary = |(event_status_ff & event_enable_ff);

	// fixed zeros in the unused positions
	assign status_low[7] = 1'b0;
	assign status_low[`ISR_SB_MASTER] = 1'b0;
	assign status_low[3] = 1'b0;
	assign status_low[1:0] = 2'h0;

	// event summary lands in bit 5
	assign status_low[`ISR_SB_EVENT] = event_summary;

	// queue bits drop only in the clear-status cycle; the queues live outside,
	// so their owner has to empty them on the same command
	assign status_low[`ISR_SB_MSG] = msg_avail & queue_gate;
	assign status_low[`ISR_SB_ERR] = err_avail & queue_gate;

	// bit 6 kept out of its own source, else the summary would loop on itself
	assign master_summary = |(status_low & req_enable_ff & sb_used);

	// the summary bit doubles as the request-service bit seen at poll
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_status_bit
			if (gi == `ISR_SB_MASTER)
			begin : g_summary
				assign status_byte_w[gi] = master_summary;
			end
			else
			begin : g_plain
				assign status_byte_w[gi] = status_low[gi];
			end
		end
	endgenerate

	// level request with no latch: it drops as soon as its cause is cleared
	assign srq_req = master_summary;

	// one select decode feeds every query answer
	assign sel_data = isr_pick(cmd_sel, event_status_ff, event_enable_ff, status_byte_w,
		req_enable_ff);

	// per-bit update: clear on read or clear-status, then OR in the event;
	// set wins over clear so an event in the clearing cycle is kept
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_event_bit
			assign event_keep[gi] = event_status_ff[gi] & ~clear_events;
			assign event_next[gi] = (event_keep[gi] | event_set[gi]) & ev_used[gi];
		end
	endgenerate

	// next value gathered in one place for the register process
	always @*
	begin
		nxt_event_status = event_next;
	end

	// event bits: hardware sets them, no bus write reaches them
	always @(posedge clk_sys)
	begin
		if (rst)
			event_status_ff <= `ISR_RST_EVENT_STATUS;
		else
			event_status_ff <= nxt_event_status;
	end

	// event enable mask; writing zero empties it
	always @(posedge clk_sys)
	begin
		if (rst)
			event_enable_ff <= `ISR_RST_EVENT_ENABLE;
		else if (wr_event_enable_hit)
			event_enable_ff <= enable_wdata;
	end

	// request enable mask, zero out of reset; status byte writes fall away
	always @(posedge clk_sys)
	begin
		if (rst)
			req_enable_ff <= `ISR_RST_REQ_ENABLE;
		else if (wr_req_enable_hit)
			req_enable_ff <= enable_wdata;
	end

	// query answer registered; an event status read hands back the value
	// from before its own clearing
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
		end
		else
		begin
			rd_valid_ff <= cmd_read;
			if (cmd_read)
				rd_data_ff <= sel_data;
		end
	end

	// poll snapshot of the status byte
	// nothing is cleared or written here, so work in progress is undisturbed
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			poll_data_ff <= 8'h00;
			poll_valid_ff <= 1'b0;
		end
		else
		begin
			poll_valid_ff <= serial_poll;
			if (serial_poll)
				poll_data_ff <= status_byte_w;
		end
	end

	// register views for the rest of the instrument
	assign event_status = event_status_ff;
	assign event_status_enable = event_enable_ff;
	assign status_byte = status_byte_w;
	assign service_request_enable = req_enable_ff;
endmodule

// file: shared/isr_consts.vh
`ifndef ISR_CONSTS_VH
`define ISR_CONSTS_VH
`define ISR_EV_PWR_ON 7
`define ISR_EV_USER_REQ 6
`define ISR_EV_CMD_ERR 5
`define ISR_EV_EXEC_ERR 4
`define ISR_EV_DEV_ERR 3
`define ISR_EV_QUERY_ERR 2
`define ISR_EV_OP_DONE 0
`define ISR_EV_USED_MASK 8'hfd
`define ISR_SB_MASTER 6
`define ISR_SB_EVENT 5
`define ISR_SB_MSG 4
`define ISR_SB_ERR 2
`define ISR_SB_USED_MASK 8'h34
`define ISR_RST_EVENT_ENABLE 8'h00
`define ISR_RST_REQ_ENABLE 8'h00
`define ISR_RST_EVENT_STATUS 8'h80
`define ISR_SEL_EVENT_STATUS 2'h0
`define ISR_SEL_EVENT_ENABLE 2'h1
`define ISR_SEL_STATUS_BYTE 2'h2
`define ISR_SEL_REQ_ENABLE 2'h3
`endif

// file: tb/isr_status_reporting_monitor.sv
`timescale 1ns/1ps
module isr_monitor
(
	input wire clk_sys,
	input wire rst,
	input wire cmd_clear_status,
	input wire cmd_read,
	input wire serial_poll,
	input wire rd_valid_ff,
	input wire poll_valid_ff,
	input wire srq_req,
	input wire [1:0] cmd_sel,
	input wire [7:0] event_set,
	input wire [7:0] poll_data_ff,
	input wire [7:0] event_status,
	input wire [7:0] event_status_enable,
	input wire [7:0] status_byte,
	input wire [7:0] service_request_enable
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// answers one cycle on; clearing checked only with no event set
	a_read_answer: assert property (cmd_read |=> rd_valid_ff) else $error("rd");
	a_poll_snap: assert property (serial_poll |=> poll_valid_ff &&
		poll_data_ff == $past(status_byte)) else $error("poll");
	a_read_clears: assert property (cmd_read && cmd_sel == 2'h0 && event_set == 8'h00
		|=> event_status == 8'h00) else $error("esr");
	a_cls_clears: assert property (cmd_clear_status && event_set == 8'h00
		|=> event_status == 8'h00) else $error("cls");
	a_event_sum: assert property (status_byte[5] ==
		|(event_status & event_status_enable)) else $error("esb");
	a_master_sum: assert property (status_byte[6] ==
		|(status_byte & service_request_enable & 8'hbf)) else $error("mss");
	a_srq_level: assert property (srq_req == status_byte[6]) else $error("srq");
	a_unused_zero: assert property (!event_status[1] && !(status_byte & 8'h8b))
		else $error("nu");
endmodule

// file: tb/isr_ctrl_model.sv
`timescale 1ns/1ps
module isr_ctrl_model
(
	input wire clk_sys,
	input wire [7:0] rd_data_ff,
	input wire [7:0] poll_data_ff,
	output reg cmd_clear_status,
	output reg cmd_write,
	output reg cmd_read,
	output reg serial_poll,
	output reg [1:0] cmd_sel,
	output reg [7:0] cmd_wdata
);
	initial {cmd_clear_status, cmd_write, cmd_read, serial_poll, cmd_sel, cmd_wdata} = 14'h0;
	// k = {clear, poll, read, write}; one-cycle strobe
	task op(input [3:0] k, input [1:0] s, input [7:0] d, output [7:0] q);
	begin
		@(negedge clk_sys);
		{cmd_clear_status, serial_poll, cmd_read, cmd_write} = k;
		cmd_sel = s;
		cmd_wdata = d;
		@(negedge clk_sys);
		{cmd_clear_status, serial_poll, cmd_read, cmd_write} = 4'h0;
		cmd_wdata = ~d; // released data is junk
		q = k[2] ? poll_data_ff : rd_data_ff;
	end
	endtask
endmodule

// file: tb/test_isr_status_reporting.sv
`timescale 1ns/1ps
module test_isr_status_reporting;
	reg clk_sys = 1'b0, rst = 1'b1, msg_avail = 1'b0, err_avail = 1'b0;
	reg [7:0] event_set = 8'h00, q;
	wire cmd_clear_status, cmd_write, cmd_read, serial_poll, rd_valid_ff, poll_valid_ff, srq_req;
	wire [1:0] cmd_sel;
	wire [7:0] cmd_wdata, rd_data_ff, poll_data_ff, event_status, event_status_enable;
	wire [7:0] status_byte, service_request_enable;
	integer errors = 0, comparisons = 0;
	always #2 clk_sys = ~clk_sys;
	isr_status_reporting isr_status_reporting_inst
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.event_set(event_set),
		.msg_avail(msg_avail),
		.err_avail(err_avail),
		.cmd_clear_status(cmd_clear_status),
		.cmd_write(cmd_write),
		.cmd_read(cmd_read),
		.cmd_sel(cmd_sel),
		.cmd_wdata(cmd_wdata),
		.serial_poll(serial_poll),
		.rd_data_ff(rd_data_ff),
		.rd_valid_ff(rd_valid_ff),
		.poll_data_ff(poll_data_ff),
		.poll_valid_ff(poll_valid_ff),
		.srq_req(srq_req),
		.event_status(event_status),
		.event_status_enable(event_status_enable),
		.status_byte(status_byte),
		.service_request_enable(service_request_enable)
	);
	isr_ctrl_model isr_ctrl_model_inst
	(
		.clk_sys(clk_sys),
		.rd_data_ff(rd_data_ff),
		.poll_data_ff(poll_data_ff),
		.cmd_clear_status(cmd_clear_status),
		.cmd_write(cmd_write),
		.cmd_read(cmd_read),
		.serial_poll(serial_poll),
		.cmd_sel(cmd_sel),
		.cmd_wdata(cmd_wdata)
	);
	task chk(input [23:0] n, input [7:0] e, input [7:0] g);
	begin
		comparisons = comparisons + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	end
	endtask
	task wr(input [1:0] s, input [7:0] d);
		isr_ctrl_model_inst.op(4'h1, s, d, q);
	endtask
	task rd(input [23:0] n, input [1:0] s, input [7:0] e);
	begin
		isr_ctrl_model_inst.op(4'h2, s, 8'h00, q);
		chk(n, e, q);
	end
	endtask
	task t_power;
	begin
		rd("esr", 2'h0, 8'h80);
		rd("esr", 2'h0, 8'h00);
		rd("sre", 2'h3, 8'h00);
	end
	endtask
	task t_summary;
	begin
		wr(2'h1, 8'hff);
		rd("ese", 2'h1, 8'hfd);
		event_set = 8'h20;
		@(negedge clk_sys) event_set = 8'h00;
		wr(2'h3, 8'h20);
		rd("stb", 2'h2, 8'h60);
		chk("srq", 8'h01, {7'h0, srq_req});
		wr(2'h1, 8'h00);
		rd("stb", 2'h2, 8'h00);
	end
	endtask
	task t_clear;
	begin
		wr(2'h0, 8'hff);
		rd("esr", 2'h0, 8'h20);
		event_set = 8'h11;
		@(negedge clk_sys) event_set = 8'h00;
		isr_ctrl_model_inst.op(4'h8, 2'h0, 8'h00, q);
		rd("esr", 2'h0, 8'h00);
		event_set = 8'h01;
		isr_ctrl_model_inst.op(4'h8, 2'h0, 8'h00, q);
		event_set = 8'h00;
		rd("esr", 2'h0, 8'h01);
		{msg_avail, err_avail} = 2'h3;
		wr(2'h3, 8'h10);
		isr_ctrl_model_inst.op(4'h4, 2'h0, 8'h00, q);
		chk("pol", 8'h54, q);
	end
	endtask
	task test_done;
	begin
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial
	begin
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		t_power;
		t_summary;
		t_clear;
		test_done;
	end
	// about 40 cycles expected
	initial
	begin
		#4000;
		errors = errors + 1;
		test_done;
	end
endmodule
bind isr_status_reporting isr_monitor isr_monitor_inst
(
	.clk_sys(clk_sys),
	.rst(rst),
	.cmd_clear_status(cmd_clear_status),
	.cmd_read(cmd_read),
	.serial_poll(serial_poll),
	.rd_valid_ff(rd_valid_ff),
	.poll_valid_ff(poll_valid_ff),
	.srq_req(srq_req),
	.cmd_sel(cmd_sel),
	.event_set(event_set),
	.poll_data_ff(poll_data_ff),
	.event_status(event_status),
	.event_status_enable(event_status_enable),
	.status_byte(status_byte),
	.service_request_enable(service_request_enable)
);
